// ### src/cbmg_pkg.sv
// Package: register map, fields, reset values and timing for the balance guard
package cbmg_pkg;
   // Clock and timebases
   localparam int CLK_HZ = 40_000_000;
   localparam int CLK_MHZ = CLK_HZ / 1_000_000;
   localparam int TICK_PERIOD_S = 1;
   localparam int TICK_CYCLES = TICK_PERIOD_S * CLK_HZ;
   localparam int SETTLE_STEP_US = 96;
   localparam int SETTLE_STEP_CYCLES = SETTLE_STEP_US * CLK_MHZ;

   // Register offsets
   localparam logic [7:0] ADDR_BAL_CTRL = 8'h00;
   localparam logic [7:0] ADDR_SW_CTRL = 8'h01;
   localparam logic [7:0] ADDR_EXP1 = 8'h02;
   localparam logic [7:0] ADDR_EXP_OTHER_FIRST = 8'h03;
   localparam logic [7:0] ADDR_EXP_OTHER_LAST = 8'h0F;
   localparam logic [7:0] ADDR_UV_THR = 8'h10;
   localparam logic [7:0] ADDR_DLY_CTRL = 8'h11;
   localparam logic [7:0] ADDR_SETTLE_DLY = 8'h12;
   localparam logic [7:0] ADDR_MEAS_CFG = 8'h13;
   localparam logic [7:0] ADDR_STATUS = 8'h14;
   localparam logic [7:0] ADDR_TIMER = 8'h15;

   // Field positions
   localparam int NUM_SW = 14;
   localparam int NUM_EXP_OTHER = 13;
   localparam int EXP_W = 10;
   localparam int RESTART_BIT = 15;
   localparam int UV_THR_W = 14;
   localparam int UV_SRC_BIT = 15;
   localparam int NTFY_LSB = 0;
   localparam int NTFY_W = 4;
   localparam int CALDLY_LSB = 8;
   localparam int CALDLY_W = 4;
   localparam int SUSPEND_BIT = 0;
   localparam int ALTMUX_BIT = 1;
   localparam int ST_REJECT_BIT = 0;
   localparam int ST_MEAS_BIT = 1;
   localparam int ST_SWITCHING_BIT = 2;
   localparam int ST_EXPIRED_BIT = 3;
   localparam int ST_SETTLE_BIT = 4;

   // Special values and reset values
   localparam logic [EXP_W-1:0] EXP_NO_TIMEOUT = 10'h3FF;
   localparam logic [EXP_W-1:0] EXP_RESET = 10'h000;
   localparam logic [15:0] SETTLE_DLY_RESET = 16'h0000;
   localparam logic [15:0] REG_RESET = 16'h0000;

   // Balance mode select encodings
   typedef enum logic [2:0] {
      CBMG_MODE_OFF = 3'h0,
      CBMG_MODE_EMERG = 3'h1,
      CBMG_MODE_MAN_A = 3'h2,
      CBMG_MODE_MAN_B = 3'h3
   } cbmg_mode_t;
endpackage : cbmg_pkg

// ### src/cbmg_settle_if.sv
// Interface: settle delay request and result between controller and timer
`timescale 1ns/10ps
interface cbmg_settle_if;
   logic acq_enable;
   logic alt_mux_select;
   logic [7:0] cell_settle_delay;
   logic [7:0] diag_settle_delay;
   logic meas_start;
   logic settle_busy;
   modport ctl (
      output acq_enable, alt_mux_select, cell_settle_delay, diag_settle_delay,
      input meas_start, settle_busy
   );
   modport timer (
      input acq_enable, alt_mux_select, cell_settle_delay, diag_settle_delay,
      output meas_start, settle_busy
   );
endinterface : cbmg_settle_if

// ### src/cbmg_settle.sv
// Settling wait between acquisition enable and measurement start
`timescale 1ns/10ps
module cbmg_settle
   import cbmg_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   cbmg_settle_if.timer sif
);
   localparam logic [11:0] STEP_LAST = 12'(SETTLE_STEP_CYCLES - 1);

   logic [11:0] step_cnt_r;
   logic [7:0] steps_left_r;
   logic busy_r;
   logic start_r;
   logic [7:0] sel_delay;

   ////////////////////////////////////////////////////////////////////////
   // Delay selection and countdown
   assign sel_delay = sif.alt_mux_select ? sif.diag_settle_delay
                                          : sif.cell_settle_delay; // RULE14

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         busy_r <= 1'b0;
         start_r <= 1'b0;
         step_cnt_r <= 12'h000;
         steps_left_r <= 8'h00;
      end else begin
         start_r <= 1'b0;
         if (!busy_r && sif.acq_enable) begin
            step_cnt_r <= 12'h000;
            if (sel_delay == 8'h00) begin
               start_r <= 1'b1; // RULE12
            end else begin
               busy_r <= 1'b1;
               steps_left_r <= sel_delay;
            end
         end else if (busy_r) begin
            if (step_cnt_r == STEP_LAST) begin
               step_cnt_r <= 12'h000;
               if (steps_left_r == 8'h01) begin
                  busy_r <= 1'b0;
                  start_r <= 1'b1; // RULE12
               end
               steps_left_r <= steps_left_r - 8'h01;
            end else begin
               step_cnt_r <= step_cnt_r + 12'h001;
            end
         end
      end
   end

   assign sif.meas_start = start_r;
   assign sif.settle_busy = busy_r;
endmodule : cbmg_settle

// ### src/cbmg_top.sv
// Balancing write guard, manual switch control and settle delay top level
// How it works
// [RULE1] Auto mode drops writes to mask, expiries, uv, notify, cal delay.
// [RULE2] Manual mode accepts all but first expiry, which is rejected.
// [RULE3] Refresh strobe self-clears and restarts watchdog only in manual.
// [RULE4] Uv threshold write rejected if min-cell source set and scanning.
// [RULE5] Nonzero mode write clears elapsed timer and relaunches the mode.
// [RULE6] Manual switch = mask AND not expired AND NOT suspended measurement.
// [RULE7] Elapsed timer runs in real time regardless of mask or suspend.
// [RULE8] First expiry 3FFh disables the watchdog timeout.
// [RULE9] Refresh after expiry is ignored; new control write needed.
// [RULE10] Manual mode ignores uv threshold; measurements run alongside.
// [RULE11] Suspend forces switches off during measurement, manual modes only.
// [RULE12] Programmable settle wait 0 to 24.48ms in 96us steps.
// [RULE13] Cell delay in upper byte, diagnostic delay in lower byte.
// [RULE14] Alternate mux 0 picks cell delay, 1 picks diagnostic delay.
// [RULE15] Settle delay writes rejected during measurement or auto mode.
// [RULE16] Timer behaviour does not depend on the suspend setting.
// [RULE17] Host should program about 960us with typical input filter.
// [RULE18] No interlock between adjacent switches in manual mode.
// [RULE19] Blocked writes are discarded and set the reject flag, except auto-mode mask writes without the strobe.
// [RULE20] Mode stays selected until software writes a new one.
// [RULE21] Measurement-in-progress input drives suspend and write rejects.
// [RULE22] One-second tick from the clock; reset clears all state.
//
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/10ps
module cbmg_top
   import cbmg_pkg::*;
#(
   parameter int TICK_CYCLES_P = TICK_CYCLES
)
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire logic meas_in_progress,
   input wire logic acq_enable,
   output logic [NUM_SW-1:0] switch_drive,
   output logic meas_start,
   output logic write_reject_flag
);
   ////////////////////////////////////////////////////////////////////////
   // State
   logic [2:0] mode_r;
   logic [NUM_SW-1:0] sw_enable_mask_r;
   logic [EXP_W-1:0] first_expiry_r;
   logic [EXP_W-1:0] other_expiry_r [NUM_EXP_OTHER];
   logic [UV_THR_W-1:0] uv_exit_threshold_r;
   logic min_cell_src_r;
   logic [NTFY_W-1:0] notify_config_r;
   logic [CALDLY_W-1:0] cal_delay_r;
   logic [15:0] settle_delay_r;
   logic meas_suspend_r;
   logic alt_mux_r;
   logic reject_r;
   logic [EXP_W-1:0] elapsed_r;
   logic [31:0] tick_cnt_r;
   logic [NUM_SW-1:0] switch_r;
   logic [NUM_SW-1:0] switch_nxt;
   logic [15:0] rdata_r;
   logic [15:0] rdata_nxt;

   logic mode_auto;
   logic mode_manual;
   logic mode_emerg;
   logic wr_ctrl;
   logic wr_sw;
   logic wr_exp1;
   logic wr_exp_other;
   logic wr_uv;
   logic wr_dly;
   logic wr_settle;
   logic wr_meas_cfg;
   logic wr_status;
   logic [7:0] other_idx;
   logic ok_sw;
   logic ok_exp1;
   logic ok_exp_other;
   logic ok_uv;
   logic ok_dly;
   logic ok_settle;
   logic reject_event;
   logic refresh;
   logic expired;
   logic tick;

   cbmg_settle_if sif ();

   ////////////////////////////////////////////////////////////////////////
   // Decode and write guard
   assign mode_auto = mode_r[2];
   assign mode_manual = (mode_r == CBMG_MODE_MAN_A) ||
                        (mode_r == CBMG_MODE_MAN_B);
   assign mode_emerg = (mode_r == CBMG_MODE_EMERG);

   assign wr_ctrl = reg_wr && (reg_addr == ADDR_BAL_CTRL);
   assign wr_sw = reg_wr && (reg_addr == ADDR_SW_CTRL);
   assign wr_exp1 = reg_wr && (reg_addr == ADDR_EXP1);
   assign wr_exp_other = reg_wr && (reg_addr >= ADDR_EXP_OTHER_FIRST) &&
                         (reg_addr <= ADDR_EXP_OTHER_LAST);
   assign wr_uv = reg_wr && (reg_addr == ADDR_UV_THR);
   assign wr_dly = reg_wr && (reg_addr == ADDR_DLY_CTRL);
   assign wr_settle = reg_wr && (reg_addr == ADDR_SETTLE_DLY);
   assign wr_meas_cfg = reg_wr && (reg_addr == ADDR_MEAS_CFG);
   assign wr_status = reg_wr && (reg_addr == ADDR_STATUS);
   assign other_idx = reg_addr - ADDR_EXP_OTHER_FIRST;

   assign ok_sw = !mode_auto; // RULE1
   assign ok_exp1 = (mode_r == CBMG_MODE_OFF); // RULE2
   assign ok_exp_other = !mode_auto; // RULE1
   assign ok_uv = !mode_auto &&
                  !(min_cell_src_r && meas_in_progress); // RULE4 RULE21
   assign ok_dly = !mode_auto && !mode_emerg; // RULE1
   assign ok_settle = !mode_auto && !meas_in_progress; // RULE15

   // Mask writes in auto mode are dropped silently, the strobe is not
   assign reject_event = (wr_sw && !ok_sw && reg_wdata[RESTART_BIT]) ||
                         (wr_exp1 && !ok_exp1) ||
                         (wr_exp_other && !ok_exp_other) ||
                         (wr_uv && !ok_uv) ||
                         (wr_dly && !ok_dly) ||
                         (wr_settle && !ok_settle); // RULE19

   // Strobe is never stored, so it reads back as zero
   assign refresh = wr_sw && reg_wdata[RESTART_BIT] && mode_manual &&
                    !expired; // RULE3 RULE9

   ////////////////////////////////////////////////////////////////////////
   // Mode register
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         mode_r <= CBMG_MODE_OFF; // RULE22
      end else if (wr_ctrl) begin
         mode_r <= reg_wdata[2:0]; // RULE20
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Configuration registers
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sw_enable_mask_r <= '0;
      end else if (wr_sw && ok_sw) begin
         sw_enable_mask_r <= reg_wdata[NUM_SW-1:0]; // RULE2
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         first_expiry_r <= EXP_RESET;
      end else if (wr_exp1 && ok_exp1) begin
         first_expiry_r <= reg_wdata[EXP_W-1:0];
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         uv_exit_threshold_r <= '0;
         min_cell_src_r <= 1'b0;
      end else if (wr_uv && ok_uv) begin
         uv_exit_threshold_r <= reg_wdata[UV_THR_W-1:0];
         min_cell_src_r <= reg_wdata[UV_SRC_BIT];
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         notify_config_r <= '0;
         cal_delay_r <= '0;
      end else if (wr_dly && ok_dly) begin
         notify_config_r <= reg_wdata[NTFY_LSB +: NTFY_W];
         cal_delay_r <= reg_wdata[CALDLY_LSB +: CALDLY_W];
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         settle_delay_r <= SETTLE_DLY_RESET;
      end else if (wr_settle && ok_settle) begin
         settle_delay_r <= reg_wdata; // RULE13
      end
   end

   // Never guarded, so suspend may change in mid-balance
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         meas_suspend_r <= 1'b0;
         alt_mux_r <= 1'b0;
      end else if (wr_meas_cfg) begin
         meas_suspend_r <= reg_wdata[SUSPEND_BIT];
         alt_mux_r <= reg_wdata[ALTMUX_BIT];
      end
   end

   // Expiries for the other cells are kept for the auto engine elsewhere
   generate
      for (genvar i = 0; i < NUM_EXP_OTHER; i++) begin : g_exp
         always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
               other_expiry_r[i] <= EXP_RESET;
            end else if (wr_exp_other && ok_exp_other &&
                         other_idx == 8'(i)) begin
               other_expiry_r[i] <= reg_wdata[EXP_W-1:0]; // RULE1
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Reject flag, write one to clear; a new event wins over the clear
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         reject_r <= 1'b0;
      end else if (reject_event) begin
         reject_r <= 1'b1; // RULE19
      end else if (wr_status && reg_wdata[ST_REJECT_BIT]) begin
         reject_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // One second timebase, restarted with the elapsed timer
   assign tick = (tick_cnt_r == 32'(TICK_CYCLES_P - 1));

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         tick_cnt_r <= 32'h00000000;
      end else if (wr_ctrl || refresh || tick) begin
         tick_cnt_r <= 32'h00000000; // RULE22
      end else begin
         tick_cnt_r <= tick_cnt_r + 32'h00000001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Elapsed timer; suspend and mask never enter here
   // Saturates so an expired watchdog stays expired
   assign expired = (first_expiry_r != EXP_NO_TIMEOUT) &&
                    (elapsed_r > first_expiry_r); // RULE8

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         elapsed_r <= '0;
      end else if (wr_ctrl) begin
         elapsed_r <= '0; // RULE5
      end else if (refresh) begin
         elapsed_r <= '0; // RULE3
      end else if (tick && (mode_r != CBMG_MODE_OFF) &&
                   (elapsed_r != EXP_NO_TIMEOUT)) begin
         elapsed_r <= elapsed_r + 10'h001; // RULE7 RULE16
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Switch drive; adjacent switches may be on together
   // Uv threshold plays no part here and scans are never held off
   always_comb begin
      switch_nxt = '0;
      if (mode_manual) begin
         for (int n = 0; n < NUM_SW; n++) begin
            switch_nxt[n] = sw_enable_mask_r[n] && !expired &&
                            !(meas_suspend_r && meas_in_progress); // RULE6
         end
      end
   end
   // RULE10 RULE11 RULE18

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         switch_r <= '0;
      end else begin
         switch_r <= switch_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Settle delay timer
   assign sif.acq_enable = acq_enable;
   assign sif.alt_mux_select = alt_mux_r; // RULE14
   assign sif.cell_settle_delay = settle_delay_r[15:8]; // RULE13
   assign sif.diag_settle_delay = settle_delay_r[7:0];

   cbmg_settle u_settle (
      .clk_sys (clk_sys),
      .rst (rst),
      .sif (sif.timer)
   );

   ////////////////////////////////////////////////////////////////////////
   // Read port
   always_comb begin
      rdata_nxt = REG_RESET;
      if (reg_rd) begin
         case (reg_addr)
            ADDR_BAL_CTRL: rdata_nxt[2:0] = mode_r;
            ADDR_SW_CTRL: rdata_nxt[NUM_SW-1:0] = sw_enable_mask_r;
            ADDR_EXP1: rdata_nxt[EXP_W-1:0] = first_expiry_r;
            ADDR_UV_THR: begin
               rdata_nxt[UV_THR_W-1:0] = uv_exit_threshold_r;
               rdata_nxt[UV_SRC_BIT] = min_cell_src_r;
            end
            ADDR_DLY_CTRL: begin
               rdata_nxt[NTFY_LSB +: NTFY_W] = notify_config_r;
               rdata_nxt[CALDLY_LSB +: CALDLY_W] = cal_delay_r;
            end
            ADDR_SETTLE_DLY: rdata_nxt = settle_delay_r;
            ADDR_MEAS_CFG: begin
               rdata_nxt[SUSPEND_BIT] = meas_suspend_r;
               rdata_nxt[ALTMUX_BIT] = alt_mux_r;
            end
            ADDR_STATUS: begin
               rdata_nxt[ST_REJECT_BIT] = reject_r;
               rdata_nxt[ST_MEAS_BIT] = meas_in_progress;
               rdata_nxt[ST_SWITCHING_BIT] = |switch_r;
               rdata_nxt[ST_EXPIRED_BIT] = expired;
               rdata_nxt[ST_SETTLE_BIT] = sif.settle_busy;
            end
            ADDR_TIMER: rdata_nxt[EXP_W-1:0] = elapsed_r;
            default: begin
               if (reg_addr >= ADDR_EXP_OTHER_FIRST &&
                   reg_addr <= ADDR_EXP_OTHER_LAST) begin
                  rdata_nxt[EXP_W-1:0] = other_expiry_r[other_idx[3:0]];
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rdata_r <= REG_RESET;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   assign reg_rdata = rdata_r;
   assign switch_drive = switch_r;
   assign meas_start = sif.meas_start;
   assign write_reject_flag = reject_r;
endmodule : cbmg_top

// ### verif/cbmg_top_asserts.sv
// Checker: port-level properties of the balance guard
`timescale 1ns/10ps
module cbmg_top_asserts
   import cbmg_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic meas_in_progress,
   input wire logic acq_enable,
   input wire logic [NUM_SW-1:0] switch_drive,
   input wire logic meas_start,
   input wire logic write_reject_flag
);
   ////////////////////////////////////////////////////////////////////////////
   // Shadow of the never-blocked mode and suspend fields and the auto-guarded mask, snooped off the bus
   logic [2:0] mode_r;
   logic susp_r;
   logic [NUM_SW-1:0] mask_r;
   logic manual;
   assign manual = (mode_r[2:1] == 2'h1);
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         mode_r <= 3'h0;
      end else if (reg_wr && reg_addr == ADDR_BAL_CTRL) begin
         mode_r <= reg_wdata[2:0];
      end
   end
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         susp_r <= 1'b0;
      end else if (reg_wr && reg_addr == ADDR_MEAS_CFG) begin
         susp_r <= reg_wdata[SUSPEND_BIT];
      end
   end
   // Auto mode drops mask writes, silently unless the strobe bit is set
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         mask_r <= '0;
      end else if (reg_wr && reg_addr == ADDR_SW_CTRL && !mode_r[2]) begin
         mask_r <= reg_wdata[NUM_SW-1:0];
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   sequence s_exp1_wr;
      reg_wr && reg_addr == ADDR_EXP1 && mode_r != 3'h0;
   endsequence
   sequence s_settle_blocked_wr;
      reg_wr && reg_addr == ADDR_SETTLE_DLY && (meas_in_progress || mode_r[2]);
   endsequence
   property p_exp1_reject;
      s_exp1_wr |=> write_reject_flag;
   endproperty
   property p_settle_reject;
      s_settle_blocked_wr |=> write_reject_flag;
   endproperty
   property p_reject_cause;
      $rose(write_reject_flag) |-> $past(reg_wr);
   endproperty
   property p_rdata_idle;
      !reg_rd |=> reg_rdata == 16'h0000;
   endproperty
   property p_unmapped_rd;
      reg_rd && reg_addr > ADDR_TIMER |=> reg_rdata == 16'h0000;
   endproperty
   property p_nonmanual_off;
      !manual |=> switch_drive == '0;
   endproperty
   property p_suspend_off;
      manual && susp_r && meas_in_progress |=> switch_drive == '0;
   endproperty
   property p_mask_bound;
      1'b1 |=> (switch_drive & ~$past(mask_r)) == '0;
   endproperty
   property p_start_pulse;
      meas_start |=> !meas_start;
   endproperty
   a_exp1_reject: assert property (p_exp1_reject)
      else $error("first expiry write not rejected");
   a_settle_reject: assert property (p_settle_reject)
      else $error("settle delay write not rejected");
   a_reject_cause: assert property (p_reject_cause)
      else $error("reject flag set without a write");
   a_rdata_idle: assert property (p_rdata_idle)
      else $error("read data not zero outside read answer");
   a_unmapped_rd: assert property (p_unmapped_rd)
      else $error("unmapped read not zero");
   a_nonmanual_off: assert property (p_nonmanual_off)
      else $error("switch on outside manual mode");
   a_suspend_off: assert property (p_suspend_off)
      else $error("switch on during suspended measurement");
   a_mask_bound: assert property (p_mask_bound)
      else $error("switch on without its mask bit");
   a_start_pulse: assert property (p_start_pulse)
      else $error("measurement start longer than one cycle");
endmodule : cbmg_top_asserts

bind cbmg_top cbmg_top_asserts cbmg_top_asserts_i (
   .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .meas_in_progress(meas_in_progress), .acq_enable(acq_enable),
   .switch_drive(switch_drive), .meas_start(meas_start),
   .write_reject_flag(write_reject_flag)
);

// ### verif/tb_cbmg_top.sv
// Testbench: write guard table, watchdog, suspend and settle delay
`timescale 1ns/10ps
module tb_cbmg_top;
   import cbmg_pkg::*;
   typedef struct {
      logic [2:0] mode;
      logic [7:0] addr;
      logic [15:0] wdata;
      logic [15:0] rd_exp;
      logic rej_exp;
   } cbmg_row_t;
   logic clk_sys, rst, reg_wr, reg_rd, meas_in_progress, acq_enable;
   logic [7:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, d;
   logic [NUM_SW-1:0] switch_drive;
   logic meas_start, write_reject_flag;
   int errors = 0;
   int compares = 0;
   int n;
   cbmg_row_t rows [17];
   // Short tick keeps the watchdog within a few dozen cycles
   cbmg_top #(.TICK_CYCLES_P(10)) cbmg_top_i (
      .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .meas_in_progress(meas_in_progress),
      .acq_enable(acq_enable), .switch_drive(switch_drive),
      .meas_start(meas_start), .write_reject_flag(write_reject_flag)
   );
   ////////////////////////////////////////////////////////////////////////////
   task automatic end_sim;
      $display("errors=%0d compares=%0d", errors, compares);
      if (errors == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : end_sim
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic tick(input int k);
      repeat (k) @(posedge clk_sys);
      #1;
   endtask : tick
   task automatic wr(input logic [7:0] a, input logic [15:0] v);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [15:0] v);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      v = reg_rdata;
   endtask : rd
   task automatic rej_chk(input logic e);
      logic [15:0] s;
      rd(ADDR_STATUS, s);
      chk({15'h0000, s[ST_REJECT_BIT]}, {15'h0000, e});
      chk({15'h0000, write_reject_flag}, {15'h0000, e});
   endtask : rej_chk
   task automatic settle(input logic [15:0] dly, input logic alt,
                         input logic [15:0] exp_n);
      wr(ADDR_SETTLE_DLY, dly);
      wr(ADDR_MEAS_CFG, {14'h0000, alt, 1'b1});
      @(posedge clk_sys);
      acq_enable <= 1'b1;
      @(posedge clk_sys);
      acq_enable <= 1'b0;
      #1;
      n = 1;
      while (meas_start !== 1'b1 && n < 40000) begin
         tick(1);
         n++;
      end
      if (n >= 40000) begin
         errors++;
      end else begin
         chk(n[15:0], exp_n);
      end
   endtask : settle
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   initial begin
      rst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 16'h0000;
      meas_in_progress = 1'b0;
      acq_enable = 1'b0;
      rows = '{
         '{3'h0, 8'h02, 16'h0005, 16'h0005, 1'b0},
         '{3'h2, 8'h02, 16'h03FF, 16'h0005, 1'b1},
         '{3'h3, 8'h01, 16'h0003, 16'h0003, 1'b0},
         '{3'h3, 8'h03, 16'h0011, 16'h0011, 1'b0},
         '{3'h2, 8'h10, 16'h0100, 16'h0100, 1'b0},
         '{3'h2, 8'h11, 16'h0305, 16'h0305, 1'b0},
         '{3'h1, 8'h02, 16'h0007, 16'h0005, 1'b1},
         '{3'h1, 8'h11, 16'h0000, 16'h0305, 1'b1},
         '{3'h1, 8'h01, 16'h0001, 16'h0001, 1'b0},
         '{3'h1, 8'h12, 16'h0102, 16'h0102, 1'b0},
         '{3'h4, 8'h01, 16'h00FF, 16'h0001, 1'b0},
         '{3'h5, 8'h03, 16'h0000, 16'h0011, 1'b1},
         '{3'h6, 8'h10, 16'h0000, 16'h0100, 1'b1},
         '{3'h7, 8'h11, 16'h0000, 16'h0305, 1'b1},
         '{3'h7, 8'h12, 16'h0000, 16'h0102, 1'b1},
         '{3'h4, 8'h01, 16'h8000, 16'h0001, 1'b1},
         '{3'h0, 8'h20, 16'hFFFF, 16'h0000, 1'b0}};
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
      foreach (rows[i]) begin
         wr(ADDR_BAL_CTRL, {13'h0000, rows[i].mode});
         rd(ADDR_BAL_CTRL, d);
         chk(d, {13'h0000, rows[i].mode});
         wr(ADDR_STATUS, 16'h0001);
         wr(rows[i].addr, rows[i].wdata);
         rej_chk(rows[i].rej_exp);
         rd(rows[i].addr, d);
         chk(d, rows[i].rd_exp);
      end
      // Watchdog: expiry, late refresh, timely refresh
      wr(ADDR_EXP1, 16'h0003);
      wr(ADDR_SW_CTRL, 16'h3FFF);
      wr(ADDR_BAL_CTRL, 16'h0002);
      tick(2);
      chk({2'h0, switch_drive}, 16'h3FFF);
      n = 2;
      while (switch_drive !== '0 && n < 200) begin
         tick(1);
         n++;
      end
      chk({15'h0000, n >= 38 && n <= 44}, 16'h0001);
      wr(ADDR_SW_CTRL, 16'hBFFF);
      tick(20);
      chk({2'h0, switch_drive}, 16'h0000);
      rd(ADDR_STATUS, d);
      chk(d, 16'h0008);
      wr(ADDR_BAL_CTRL, 16'h0002);
      tick(30);
      wr(ADDR_SW_CTRL, 16'hBFFF);
      tick(30);
      chk({2'h0, switch_drive}, 16'h3FFF);
      tick(20);
      chk({2'h0, switch_drive}, 16'h0000);
      // Suspend during measurement, no-timeout limit, scan-time rejects
      wr(ADDR_BAL_CTRL, 16'h0000);
      wr(ADDR_EXP1, 16'h03FF);
      wr(ADDR_MEAS_CFG, 16'h0001);
      wr(ADDR_UV_THR, 16'h8000);
      wr(ADDR_BAL_CTRL, 16'h0002);
      wr(ADDR_STATUS, 16'h0001);
      @(posedge clk_sys);
      meas_in_progress <= 1'b1;
      tick(2);
      chk({2'h0, switch_drive}, 16'h0000);
      wr(ADDR_UV_THR, 16'h8123);
      rej_chk(1'b1);
      rd(ADDR_UV_THR, d);
      chk(d, 16'h8000);
      wr(ADDR_STATUS, 16'h0001);
      wr(ADDR_SETTLE_DLY, 16'h0505);
      rej_chk(1'b1);
      @(posedge clk_sys);
      meas_in_progress <= 1'b0;
      tick(60);
      chk({2'h0, switch_drive}, 16'h3FFF);
      // Reset in mid-run clears switches and configuration
      @(posedge clk_sys);
      rst <= 1'b1;
      tick(2);
      chk({2'h0, switch_drive}, 16'h0000);
      @(posedge clk_sys);
      rst <= 1'b0;
      rd(ADDR_BAL_CTRL, d);
      chk(d, 16'h0000);
      rd(ADDR_EXP1, d);
      chk(d, 16'h0000);
      // Settle delay byte selection
      settle(16'h0001, 1'b0, 16'h0001);
      settle(16'h0001, 1'b1, 16'(1 + SETTLE_STEP_CYCLES));
      settle(16'h0A00, 1'b0, 16'(1 + 10 * SETTLE_STEP_CYCLES));
      end_sim();
   end
endmodule : tb_cbmg_top
